// >>> core/group_map_pkg.sv
// Constants, offsets and types shared by the group variable map design.
// ============================================================
// Operation
// [R1] Answer unit equal to own group number
// [R2] Unit 0 shows all, offset 100*(group-1)
// [R3] Read-only read, write-class written by master
// [R4] Read-write values may change by themselves
// [R5] Input filter counts in 100 us steps
// [R6] Watchdog period counts in milliseconds
// [R7] Read-only flag shows watchdog caused restart
// [R8] Writing clear variable drops watchdog flag
// [R9] Pulse width gives high counts per cycle
// [R10] Per-input edge counter, readable and presettable
// [R11] Write-only direct switch enable, invert, flip
// [R12] Read-only count of unsent transmit bytes
// [R13] Output state read-write, input level read-only
// [R14] Preset store write saves current settings
// [R15] Only group I/O variables are mapped
// [R16] Reboot write restarts and loads presets
// [R17] One-wire disable defaults false, true disables
// [R18] Write-only current input selection
// [R19] Read-only firmware, board revision, serial number
// [R20] Writes to read-only variables change nothing
package group_map_pkg;
  // ============================================================
  // Sizes and timing
  localparam int NUM_IO = 4;
  localparam int DW = 16;
  localparam int CLK_MHZ = 20;
  localparam int FILTER_STEP_US = 100;
  localparam int FILTER_STEP_CYC = FILTER_STEP_US * CLK_MHZ;
  localparam int WD_STEP_MS = 1;
  localparam int WD_STEP_CYC_DEF = WD_STEP_MS * 1000 * CLK_MHZ;
  // ============================================================
  // Address fields: unit in bits 13:12, register number in 11:2
  localparam int UNIT_LSB = 12;
  localparam int UNIT_W = 2;
  localparam int REG_LSB = 2;
  localparam int REG_W = 10;
  localparam int UNIT_SHIFT = 100;
  localparam logic [1:0] AGG_UNIT = 2'h0;
  // ============================================================
  // Register numbers
  localparam logic [9:0] IDX_OUT = 10'h000;
  localparam logic [9:0] IDX_IN = 10'h001;
  localparam logic [9:0] IDX_DEBOUNCE = 10'h002;
  localparam logic [9:0] IDX_CYCLE = 10'h003;
  localparam logic [9:0] IDX_PRESCALE = 10'h004;
  localparam logic [9:0] IDX_PWM0 = 10'h005;
  localparam logic [9:0] IDX_CNT0 = 10'h009;
  localparam logic [9:0] IDX_DS_ON = 10'h00D;
  localparam logic [9:0] IDX_DS_INV = 10'h00E;
  localparam logic [9:0] IDX_DS_FLIP = 10'h00F;
  localparam logic [9:0] IDX_CUR_SEL = 10'h010;
  localparam logic [9:0] IDX_WD_ON = 10'h011;
  localparam logic [9:0] IDX_WD_PERIOD = 10'h012;
  localparam logic [9:0] IDX_WD_FLAG = 10'h013;
  localparam logic [9:0] IDX_WD_CLEAR = 10'h014;
  localparam logic [9:0] IDX_TXQ = 10'h015;
  localparam logic [9:0] IDX_PRESET = 10'h016;
  localparam logic [9:0] IDX_OW_DIS = 10'h017;
  localparam logic [9:0] IDX_FW = 10'h018;
  localparam logic [9:0] IDX_BREV = 10'h019;
  localparam logic [9:0] IDX_SER_LO = 10'h01A;
  localparam logic [9:0] IDX_SER_HI = 10'h01B;
  localparam logic [9:0] IDX_REBOOT = 10'h01C;
  localparam logic [9:0] IDX_COUNT = 10'h01D;
  // ============================================================
  // Reset values
  localparam logic [15:0] RST_DEBOUNCE = 16'h0000;
  localparam logic [15:0] RST_CYCLE = 16'h0064;
  localparam logic [15:0] RST_PRESCALE = 16'h0000;
  localparam logic [15:0] RST_WD_PERIOD = 16'h03E8;
  // ============================================================
  // Restart sequencer, one bit changes per step except HOLD to RUN
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_LOAD = 2'b01,
    ST_HOLD = 2'b11
  } restart_state_t;
endpackage

// >>> core/input_filter.sv
// One digital input: step filter, rising-edge pulse and edge counter.
`timescale 1ns/1ps
module input_filter (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Settings and input
  input wire logic step,
  input wire logic [15:0] debounce,
  input wire logic raw,
  // Counter preset
  input wire logic cnt_wr,
  input wire logic [15:0] cnt_wdata,
  // Results
  output logic level,
  output logic rise,
  output logic [15:0] count
);
  logic [15:0] timer_r;
  logic settle;

  // A change is taken only once the input held the new value for the whole span
  assign settle = (raw != level) && (timer_r >= debounce);

  // ============================================================
  // Filter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_r <= 16'h0000;
      level <= 1'b0;
      rise <= 1'b0;
    end else begin
      rise <= settle && raw; // [R5]
      if (raw == level) begin
        timer_r <= 16'h0000;
      end else if (settle) begin
        level <= raw; // [R5]
        timer_r <= 16'h0000;
      end else if (step) begin
        timer_r <= timer_r + 16'h0001;
      end
    end
  end

  // ============================================================
  // Counter; a preset that meets an edge keeps the edge, wraps at the top
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 16'h0000;
    end else if (cnt_wr) begin
      count <= rise ? cnt_wdata + 16'h0001 : cnt_wdata; // [R10]
    end else if (rise) begin
      count <= count + 16'h0001; // [R4]
    end
  end
endmodule // input_filter

// >>> core/pwm_channel.sv
// One pulse-width channel with its own prescaler and phase counter.
`timescale 1ns/1ps
module pwm_channel (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic restart,
  // Settings
  input wire logic [15:0] prescale,
  input wire logic [15:0] cycle,
  input wire logic [15:0] width,
  // Result
  output logic pwm_high
);
  logic [15:0] pre_r;
  logic [15:0] phase_r;

  // ============================================================
  // Phase runs 0..cycle, one step per prescale+1 clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= 16'h0000;
      phase_r <= 16'h0000;
      pwm_high <= 1'b0;
    end else if (restart) begin
      pre_r <= 16'h0000;
      phase_r <= 16'h0000;
      pwm_high <= 1'b0;
    end else begin
      pwm_high <= phase_r < width; // [R9]
      if (pre_r >= prescale) begin
        pre_r <= 16'h0000;
        phase_r <= (phase_r >= cycle) ? 16'h0000 : phase_r + 16'h0001;
      end else begin
        pre_r <= pre_r + 16'h0001;
      end
    end
  end
endmodule // pwm_channel

// >>> core/group_var_map.sv
// One I/O group's variable map behind an APB slave, with unit decoding.
`timescale 1ns/1ps
module group_var_map #(
  parameter logic [1:0] GROUP_NUM = 2'h1,
  parameter int WD_STEP_CYC = group_map_pkg::WD_STEP_CYC_DEF,
  parameter logic [15:0] FW_VERSION = 16'h0100, // Arbitrary value
  parameter logic [15:0] BOARD_REV = 16'h0011, // Arbitrary value
  parameter logic [31:0] BOARD_SERIAL = 32'h00000001 // Arbitrary value
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Group pins
  input wire logic [group_map_pkg::NUM_IO-1:0] input_pins,
  input wire logic [15:0] tx_pending_bytes,
  output logic [group_map_pkg::NUM_IO-1:0] output_drive,
  output logic current_input_select,
  output logic onewire_disable,
  output logic group_restart
);
  import group_map_pkg::*;

  localparam logic [9:0] GROUP_BASE = 10'(UNIT_SHIFT * (int'(GROUP_NUM) - 1));
  localparam logic [9:0] GROUP_TOP = 10'(UNIT_SHIFT * int'(GROUP_NUM));

  // Returns {hit, local register number}; only group I/O variables exist
  function automatic logic [10:0] decode(input logic [15:0] a);
    logic [1:0] unit;
    logic [9:0] num;
    logic [10:0] r;
    unit = a[UNIT_LSB +: UNIT_W];
    num = a[REG_LSB +: REG_W];
    r = 11'h000;
    if (unit == GROUP_NUM) begin
      r = {1'b1, num}; // [R1]
    end else if (unit == AGG_UNIT && num >= GROUP_BASE && num < GROUP_TOP) begin
      r = {1'b1, num - GROUP_BASE}; // [R2]
    end
    if (r[9:0] >= IDX_COUNT) begin
      r = 11'h000; // [R15]
    end
    return r;
  endfunction

  logic [10:0] dec_acc;
  logic [10:0] dec_set;
  logic [9:0] wr_idx;
  logic [15:0] wdata;
  logic access;
  logic wr_en;
  logic [15:0] rd_val;
  logic [3:0] do_r;
  logic [3:0] do_nxt;
  logic [15:0] pwm_width_r [NUM_IO];
  logic [15:0] cycle_r;
  logic [15:0] prescale_r;
  logic [15:0] debounce_r;
  logic [3:0] ds_on_r;
  logic [3:0] ds_inv_r;
  logic [3:0] ds_flip_r;
  logic wd_on_r;
  logic [15:0] wd_period_r;
  logic wd_flag_r;
  logic [3:0] pre_do_r;
  logic [15:0] pre_width_r [NUM_IO];
  logic [15:0] pre_cycle_r;
  logic [15:0] pre_prescale_r;
  logic [15:0] pre_debounce_r;
  logic [3:0] pre_ds_on_r;
  logic [3:0] pre_ds_inv_r;
  logic [3:0] pre_ds_flip_r;
  logic pre_cur_r;
  logic [11:0] filt_div_r;
  logic filt_tick;
  logic [31:0] wd_div_r;
  logic wd_tick;
  logic [15:0] wd_ms_r;
  logic wd_fire;
  logic reboot_req;
  restart_state_t st_r;
  logic restart_load;
  logic [3:0] level;
  logic [3:0] rise;
  logic [3:0] pwm_hi;
  logic [15:0] count [NUM_IO];
  logic [3:0] cnt_wr;

  // ============================================================
  // APB: no wait state; read data and answer come from flops latched in the setup cycle
  assign dec_set = decode(paddr);
  assign dec_acc = decode(paddr);
  assign wr_idx = dec_acc[9:0];
  assign wdata = pwdata[15:0];
  assign access = psel && penable && pready && dec_acc[10];
  assign wr_en = access && pwrite;
  assign restart_load = (st_r == ST_LOAD);

  // Read view; write-class variables read as zero
  always_comb begin
    rd_val = 16'h0000;
    case (dec_set[9:0])
      IDX_OUT: rd_val = {12'h000, do_r}; // [R13]
      IDX_IN: rd_val = {12'h000, level}; // [R13]
      IDX_WD_FLAG: rd_val = {15'h0000, wd_flag_r}; // [R7]
      IDX_TXQ: rd_val = tx_pending_bytes; // [R12]
      IDX_FW: rd_val = FW_VERSION; // [R19]
      IDX_BREV: rd_val = BOARD_REV; // [R19]
      IDX_SER_LO: rd_val = BOARD_SERIAL[15:0]; // [R19]
      IDX_SER_HI: rd_val = BOARD_SERIAL[31:16]; // [R19]
      default: rd_val = 16'h0000; // [R3]
    endcase
    for (int i = 0; i < NUM_IO; i++) begin
      if (dec_set[9:0] == 10'(int'(IDX_CNT0) + i)) begin
        rd_val = count[i]; // [R10]
      end
    end
  end

  // Answer latched in the setup cycle, ready for the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !dec_set[10]; // [R15]
      if (psel && !penable && !pwrite) begin
        prdata <= {16'h0000, rd_val};
      end
    end
  end

  // ============================================================
  // Settings written by the master; a restart reloads the presets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cycle_r <= RST_CYCLE;
      prescale_r <= RST_PRESCALE;
      debounce_r <= RST_DEBOUNCE;
      ds_on_r <= 4'h0;
      ds_inv_r <= 4'h0;
      ds_flip_r <= 4'h0;
      current_input_select <= 1'b0;
      wd_on_r <= 1'b0;
      wd_period_r <= RST_WD_PERIOD;
      onewire_disable <= 1'b0; // [R17]
      for (int i = 0; i < NUM_IO; i++) begin
        pwm_width_r[i] <= 16'h0000;
      end
    end else if (restart_load) begin
      cycle_r <= pre_cycle_r; // [R16]
      prescale_r <= pre_prescale_r;
      debounce_r <= pre_debounce_r;
      ds_on_r <= pre_ds_on_r;
      ds_inv_r <= pre_ds_inv_r;
      ds_flip_r <= pre_ds_flip_r;
      current_input_select <= pre_cur_r;
      onewire_disable <= 1'b0; // [R17]
      for (int i = 0; i < NUM_IO; i++) begin
        pwm_width_r[i] <= pre_width_r[i];
      end
    end else if (wr_en) begin
      // Read-only numbers fall to the default branch and change nothing
      case (wr_idx)
        IDX_DEBOUNCE: debounce_r <= wdata; // [R5]
        IDX_CYCLE: cycle_r <= wdata;
        IDX_PRESCALE: prescale_r <= wdata;
        IDX_DS_ON: ds_on_r <= wdata[3:0]; // [R11]
        IDX_DS_INV: ds_inv_r <= wdata[3:0]; // [R11]
        IDX_DS_FLIP: ds_flip_r <= wdata[3:0]; // [R11]
        IDX_CUR_SEL: current_input_select <= wdata[0]; // [R18]
        IDX_WD_ON: wd_on_r <= wdata[0];
        IDX_WD_PERIOD: wd_period_r <= wdata; // [R6]
        IDX_OW_DIS: onewire_disable <= wdata[0]; // [R17]
        default: ; // [R20]
      endcase
      for (int i = 0; i < NUM_IO; i++) begin
        if (wr_idx == 10'(int'(IDX_PWM0) + i)) begin
          pwm_width_r[i] <= wdata; // [R9]
        end
      end
    end
  end

  // Output state: master write, then direct switch on enabled inputs
  always_comb begin
    do_nxt = do_r;
    if (wr_en && wr_idx == IDX_OUT) begin
      do_nxt = wdata[3:0]; // [R13]
    end
    for (int i = 0; i < NUM_IO; i++) begin
      if (ds_on_r[i] && ds_flip_r[i]) begin
        do_nxt[i] = rise[i] ? !do_r[i] : do_nxt[i]; // [R11]
      end else if (ds_on_r[i]) begin
        do_nxt[i] = level[i] ^ ds_inv_r[i]; // [R11]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      do_r <= 4'h0;
    end else begin
      do_r <= restart_load ? pre_do_r : do_nxt; // [R4]
    end
  end

  // ============================================================
  // Preset store: snapshot of the settings reloaded on every restart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_do_r <= 4'h0;
      pre_cycle_r <= RST_CYCLE;
      pre_prescale_r <= RST_PRESCALE;
      pre_debounce_r <= RST_DEBOUNCE;
      pre_ds_on_r <= 4'h0;
      pre_ds_inv_r <= 4'h0;
      pre_ds_flip_r <= 4'h0;
      pre_cur_r <= 1'b0;
      for (int i = 0; i < NUM_IO; i++) begin
        pre_width_r[i] <= 16'h0000;
      end
    end else if (wr_en && wr_idx == IDX_PRESET && wdata[0]) begin
      pre_do_r <= do_r; // [R14]
      pre_cycle_r <= cycle_r;
      pre_prescale_r <= prescale_r;
      pre_debounce_r <= debounce_r;
      pre_ds_on_r <= ds_on_r;
      pre_ds_inv_r <= ds_inv_r;
      pre_ds_flip_r <= ds_flip_r;
      pre_cur_r <= current_input_select;
      for (int i = 0; i < NUM_IO; i++) begin
        pre_width_r[i] <= pwm_width_r[i];
      end
    end
  end

  // ============================================================
  // Time bases: 100 us filter step and 1 ms watchdog step
  assign filt_tick = (filt_div_r == 12'(FILTER_STEP_CYC - 1));
  assign wd_tick = (wd_div_r == 32'(WD_STEP_CYC - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_div_r <= 12'h000;
      wd_div_r <= 32'h00000000;
    end else begin
      filt_div_r <= filt_tick ? 12'h000 : filt_div_r + 12'h001; // [R5]
      wd_div_r <= wd_tick ? 32'h00000000 : wd_div_r + 32'h00000001; // [R6]
    end
  end

  // ============================================================
  // Watchdog: any mapped access counts as master traffic
  assign wd_fire = wd_on_r && (wd_period_r != 16'h0000) && (wd_ms_r >= wd_period_r) && (st_r == ST_RUN);
  assign reboot_req = wr_en && wr_idx == IDX_REBOOT && wdata[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_ms_r <= 16'h0000;
    end else if (!wd_on_r || access || st_r != ST_RUN) begin
      wd_ms_r <= 16'h0000;
    end else if (wd_tick && wd_ms_r != 16'hFFFF) begin
      wd_ms_r <= wd_ms_r + 16'h0001; // [R6]
    end
  end

  // Flag: a firing watchdog wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_flag_r <= 1'b0;
    end else if (wd_fire) begin
      wd_flag_r <= 1'b1; // [R7]
    end else if (wr_en && wr_idx == IDX_WD_CLEAR && wdata[0]) begin
      wd_flag_r <= 1'b0; // [R8]
    end
  end

  // Restart sequencer: load presets, then hold restart one more cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_RUN;
      group_restart <= 1'b0;
    end else begin
      group_restart <= restart_load;
      case (st_r)
        ST_RUN: st_r <= (wd_fire || reboot_req) ? ST_LOAD : ST_RUN; // [R16]
        ST_LOAD: st_r <= ST_HOLD;
        ST_HOLD: st_r <= ST_RUN;
        default: st_r <= ST_RUN;
      endcase
    end
  end

  // ============================================================
  // Per-channel inputs and outputs
  genvar g;
  generate
    for (g = 0; g < NUM_IO; g++) begin : g_io
      assign cnt_wr[g] = wr_en && (wr_idx == 10'(int'(IDX_CNT0) + g));
      input_filter u_in (
        .pclk(pclk),
        .presetn(presetn),
        .step(filt_tick),
        .debounce(debounce_r),
        .raw(input_pins[g]),
        .cnt_wr(cnt_wr[g]),
        .cnt_wdata(wdata),
        .level(level[g]),
        .rise(rise[g]),
        .count(count[g])
      );
      pwm_channel u_pwm (
        .pclk(pclk),
        .presetn(presetn),
        .restart(restart_load),
        .prescale(prescale_r),
        .cycle(cycle_r),
        .width(pwm_width_r[g]),
        .pwm_high(pwm_hi[g])
      );
      // Output on ignores the pulse width
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          output_drive[g] <= 1'b0;
        end else begin
          output_drive[g] <= do_r[g] || (pwm_width_r[g] != 16'h0000 && pwm_hi[g]); // [R9]
        end
      end
    end
  endgenerate

  // ============================================================
  // Checks
  logic [11:0] gap_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_r <= 12'h000;
    end else begin
      gap_r <= filt_tick ? 12'h000 : gap_r + 12'h001;
    end
  end

  property p_unit_own;
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && paddr[13:12] == GROUP_NUM && paddr[11:2] == IDX_OUT && !pwrite
    |=> pready && !pslverr && prdata[3:0] == $past(do_r);
  endproperty
  a_unit_own: assert property (p_unit_own) else $error("own unit read wrong"); // [R1]

  property p_unit_agg;
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && paddr[13:12] == AGG_UNIT && paddr[11:2] == GROUP_BASE + IDX_IN && !pwrite
    |=> pready && !pslverr && prdata[3:0] == $past(level);
  endproperty
  a_unit_agg: assert property (p_unit_agg) else $error("unit 0 shifted read wrong"); // [R2]

  property p_unmapped;
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && paddr[11:2] >= IDX_COUNT && paddr[13:12] == GROUP_NUM |=> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped number answered"); // [R15]

  property p_ro_write;
    @(posedge pclk) disable iff (!presetn)
    wr_en && wr_idx == IDX_WD_FLAG && !wd_fire |=> $stable(wd_flag_r) && $stable(wd_period_r);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only write changed state"); // [R20]

  property p_filter_step;
    @(posedge pclk) disable iff (!presetn)
    filt_tick && $past(filt_tick) == 1'b0 && gap_r != 12'h000 |-> gap_r == 12'(FILTER_STEP_CYC - 1);
  endproperty
  a_filter_step: assert property (p_filter_step) else $error("filter step not 100 us"); // [R5]

  property p_wd_fire;
    @(posedge pclk) disable iff (!presetn)
    wd_fire |=> wd_flag_r && st_r == ST_LOAD ##1 group_restart && st_r == ST_HOLD ##1 st_r == ST_RUN;
  endproperty
  a_wd_fire: assert property (p_wd_fire) else $error("watchdog restart sequence wrong"); // [R7]

  property p_wd_clear;
    @(posedge pclk) disable iff (!presetn)
    wr_en && wr_idx == IDX_WD_CLEAR && wdata[0] && !wd_fire |=> !wd_flag_r;
  endproperty
  a_wd_clear: assert property (p_wd_clear) else $error("watchdog flag not cleared"); // [R8]

  property p_cnt_preset;
    @(posedge pclk) disable iff (!presetn)
    cnt_wr[0] && !rise[0] |=> count[0] == $past(wdata);
  endproperty
  a_cnt_preset: assert property (p_cnt_preset) else $error("counter preset lost"); // [R10]

  property p_ds_follow;
    @(posedge pclk) disable iff (!presetn)
    ds_on_r[0] && !ds_flip_r[0] && !restart_load |=> do_r[0] == $past(level[0] ^ ds_inv_r[0]) ##1
    output_drive[0] == ($past(do_r[0]) || ($past(pwm_width_r[0]) != 16'h0000 && $past(pwm_hi[0])));
  endproperty
  a_ds_follow: assert property (p_ds_follow) else $error("direct switch not followed"); // [R11]

  property p_preset_reload;
    @(posedge pclk) disable iff (!presetn)
    restart_load |=> do_r == $past(pre_do_r) && cycle_r == $past(pre_cycle_r) && !onewire_disable;
  endproperty
  a_preset_reload: assert property (p_preset_reload) else $error("presets not reloaded"); // [R16]
endmodule // group_var_map

// >>> testbench/apb_master_model.sv
// APB master standing in for the master control program on the group bus.
`timescale 1ns/1ps
module apb_master_model (
  // Clock
  input wire logic pclk,
  // APB request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [15:0] paddr,
  output logic [31:0] pwdata,
  // APB answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ============================================================
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h00000000;
  end
  // One transfer, entered right after a rising edge; request held until pready is sampled high or 20 edges pass
  // Answer is taken at that same rising edge, before the slave's flops move on
  task automatic xfer(input logic [1:0] u, input logic [9:0] n, input logic w, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err, output logic hung);
    int k;
    logic got;
    k = 0;
    got = 1'b0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'h0, u, n, 2'h0};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    while (!got && k < 20) begin
      @(posedge pclk);
      got = (pready === 1'b1);
      k++;
    end
    rd = prdata;
    err = pslverr;
    hung = !got;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
endmodule // apb_master_model

// >>> testbench/test_group_var_map.sv
// Self-checking bench for one group's variable map, group number 2.
`timescale 1ns/1ps
module test_group_var_map;
  import group_map_pkg::*;
  localparam logic [1:0] G = 2'h2;
  localparam logic [15:0] FW = 16'h0A05; // Arbitrary value
  localparam logic [15:0] BREV = 16'h0C21; // Arbitrary value
  localparam logic [31:0] SER = 32'h5A3C0F11; // Arbitrary value
  `define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
    $display("[ERR] %0t mismatch got %h exp %h", $time, (a), (b)); end end
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, cur_sel, ow_dis, restart;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] input_pins = 4'h0;
  logic [3:0] output_drive;
  logic [15:0] tx_pending_bytes = 16'h0000;
  int err_count = 0;
  int num_checks = 0;
  int rc = 0;
  int n = 0;
  // ============================================================
  // Clock, restart pulse counter, partner and design
  always #25 pclk = ~pclk;
  always @(posedge pclk) if (restart === 1'b1) rc <= rc + 1;
  apb_master_model M (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  group_var_map #(.GROUP_NUM(G), .WD_STEP_CYC(20), .FW_VERSION(FW), .BOARD_REV(BREV), .BOARD_SERIAL(SER)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .input_pins(input_pins),
    .tx_pending_bytes(tx_pending_bytes), .output_drive(output_drive), .current_input_select(cur_sel),
    .onewire_disable(ow_dis), .group_restart(restart));
  // ============================================================
  // Verdict; a hung transfer comes here too
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Access with expected error flag; reads expected to succeed also compare the whole word
  task automatic acc(input logic [1:0] u, input logic [9:0] n, input logic w, input logic [15:0] d, input logic e);
    logic [31:0] r;
    logic er, h;
    M.xfer(u, n, w, {16'h0000, d}, r, er, h);
    if (h) begin
      err_count++;
      end_sim();
    end
    `CHK(er, e)
    if (!w && !e) `CHK(r, {16'h0000, d})
  endtask
  // ============================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK(ow_dis, 1'b0)
    acc(2'h0, 10'd100 + IDX_FW, 1'b0, FW, 1'b0);
    acc(G, IDX_BREV, 1'b0, BREV, 1'b0);
    acc(G, IDX_SER_LO, 1'b0, SER[15:0], 1'b0);
    acc(G, IDX_SER_HI, 1'b0, SER[31:16], 1'b0);
    acc(G, IDX_FW, 1'b1, 16'h1234, 1'b0);
    acc(G, IDX_FW, 1'b0, FW, 1'b0);
    acc(2'h1, IDX_OUT, 1'b0, 16'h0000, 1'b1);
    acc(2'h3, IDX_OUT, 1'b1, 16'h000F, 1'b1);
    acc(2'h0, 10'd99, 1'b0, 16'h0000, 1'b1);
    acc(G, IDX_COUNT, 1'b0, 16'h0000, 1'b1);
    acc(G, IDX_OUT, 1'b1, 16'h0005, 1'b0);
    // Pins lag the output state by one flop
    @(posedge pclk);
    `CHK(output_drive, 4'h5)
    acc(2'h0, 10'd100 + IDX_OUT, 1'b0, 16'h0005, 1'b0);
    acc(G, IDX_DEBOUNCE, 1'b0, 16'h0000, 1'b0);
    tx_pending_bytes <= 16'h0033;
    input_pins <= 4'h1;
    repeat (10) @(posedge pclk);
    acc(G, IDX_TXQ, 1'b0, 16'h0033, 1'b0);
    acc(G, IDX_IN, 1'b0, 16'h0001, 1'b0);
    acc(2'h0, 10'd100 + IDX_IN, 1'b0, 16'h0001, 1'b0);
    acc(G, IDX_CNT0, 1'b0, 16'h0001, 1'b0);
    acc(G, IDX_CNT0, 1'b1, 16'h0007, 1'b0);
    acc(G, IDX_CNT0, 1'b0, 16'h0007, 1'b0);
    // Direct switch, inverted: input 0 high forces output 0 low
    acc(G, IDX_DS_INV, 1'b1, 16'h0001, 1'b0);
    acc(G, IDX_DS_ON, 1'b1, 16'h0001, 1'b0);
    acc(G, IDX_OUT, 1'b0, 16'h0004, 1'b0);
    acc(G, IDX_DS_ON, 1'b1, 16'h0000, 1'b0);
    // Pulse width 2 of a 4-step cycle: half of 8 samples high
    acc(G, IDX_CYCLE, 1'b1, 16'h0003, 1'b0);
    acc(G, IDX_PWM0 + 10'd1, 1'b1, 16'h0002, 1'b0);
    @(posedge pclk);
    repeat (8) begin
      @(posedge pclk);
      n += int'(output_drive[1]);
    end
    `CHK(n, 4)
    // One filter step of debounce: the rise waits for the 100 us tick, then toggles output 1
    acc(G, IDX_DEBOUNCE, 1'b1, 16'h0001, 1'b0);
    acc(G, IDX_DS_FLIP, 1'b1, 16'h0002, 1'b0);
    acc(G, IDX_DS_ON, 1'b1, 16'h0002, 1'b0);
    input_pins <= 4'h3;
    repeat (10) @(posedge pclk);
    acc(G, IDX_IN, 1'b0, 16'h0001, 1'b0);
    repeat (2100) @(posedge pclk);
    acc(G, IDX_IN, 1'b0, 16'h0003, 1'b0);
    acc(G, IDX_CNT0 + 10'd1, 1'b0, 16'h0001, 1'b0);
    acc(G, IDX_OUT, 1'b0, 16'h0006, 1'b0);
    acc(G, IDX_DS_ON, 1'b1, 16'h0000, 1'b0);
    acc(G, IDX_CUR_SEL, 1'b1, 16'h0001, 1'b0);
    acc(G, IDX_OW_DIS, 1'b1, 16'h0001, 1'b0);
    `CHK({cur_sel, ow_dis}, 2'b11)
    acc(G, IDX_OUT, 1'b1, 16'h0003, 1'b0);
    acc(G, IDX_PRESET, 1'b1, 16'h0001, 1'b0);
    acc(G, IDX_OUT, 1'b1, 16'h0000, 1'b0);
    acc(G, IDX_REBOOT, 1'b1, 16'h0001, 1'b0);
    repeat (5) @(posedge pclk);
    `CHK(rc, 1)
    `CHK(ow_dis, 1'b0)
    acc(G, IDX_OUT, 1'b0, 16'h0003, 1'b0);
    // Period 2 ms fires between 21 and 40 clocks of silence at the shortened step
    acc(G, IDX_WD_PERIOD, 1'b1, 16'h0002, 1'b0);
    acc(G, IDX_WD_ON, 1'b1, 16'h0001, 1'b0);
    repeat (20) @(posedge pclk);
    `CHK(rc, 1)
    repeat (40) @(posedge pclk);
    `CHK(rc, 2)
    acc(G, IDX_WD_FLAG, 1'b0, 16'h0001, 1'b0);
    acc(G, IDX_WD_FLAG, 1'b1, 16'h0000, 1'b0);
    acc(G, IDX_WD_FLAG, 1'b0, 16'h0001, 1'b0);
    acc(G, IDX_WD_CLEAR, 1'b1, 16'h0001, 1'b0);
    acc(G, IDX_WD_FLAG, 1'b0, 16'h0000, 1'b0);
    end_sim();
  end
endmodule // test_group_var_map
